// ### rtl/sbd_pkg.sv
package sbd_pkg;

	// host bus address and decode layout
	localparam int ADDR_W = 16;
	localparam int DEC_HI = 9;
	localparam int DEC_LO = 2;
	localparam int JMP_W = 8;
	localparam int OFS_W = 2;
	localparam logic [OFS_W-1:0] OFS_DATA = 2'h0;
	localparam logic [OFS_W-1:0] OFS_CTRL = 2'h1;

	// fitted jumper (1) demands address bit 0; factory set gives base 0x2B0
	localparam logic [JMP_W-1:0] JMP_FACTORY = 8'h53;

	// interrupt line selection: IRQ2..IRQ7 as bits 0..5
	localparam int IRQ_N = 6;

	// channels and measurement width
	localparam int CH_N = 8;
	localparam int CH_W = 3;
	localparam int MEAS_W = 16;

	// scan step time
	localparam int CLK_MHZ = 250;
	localparam int SCAN_STEP_NS = 1000;
	localparam int SCAN_STEP_CYC = (SCAN_STEP_NS * CLK_MHZ) / 1000;
	localparam logic [15:0] SCAN_LAST = 16'(SCAN_STEP_CYC - 1);

	// status register bits
	localparam int ST_ALARM = 0;
	localparam int ST_RXRDY = 1;
	localparam int ST_TXBUSY = 2;
	// control register bits
	localparam int CT_IEN_ALARM = 0;
	localparam int CT_IEN_COMM = 1;
	localparam int CT_ACK_ALARM = 2;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic aen;
		logic ior_n;
		logic iow_n;
		logic [7:0] wdata;
	} sbd_bus_type;

	typedef struct packed {
		logic signed [MEAS_W-1:0] lo;
		logic signed [MEAS_W-1:0] hi;
	} sbd_limit_type;

endpackage : sbd_pkg

// ### rtl/sbd_io_decode.sv
`timescale 1ns/100ps
// Contract
// [R1] claim aligned four-byte block, answer first two
// [R2] compare only low ten address bits
// [R3] jumpers one to eight set bits two-nine
// [R4] fitted jumper means zero, absent means one
// [R5] factory jumpers give base 0x2B0, irq off
// [R6] all interrupt sources share one request
// [R7] irq jumper picks IRQ2-IRQ7, none drives nothing
// [R8] scan eight channels forever, keep newest results
// [R9] per-channel limits raise alarm status flag
// [R10] offset zero is command/response data port
// [R11] offset one: status read, control write
// [R12] decode requires address enable inactive
module sbd_io_decode
	import sbd_pkg::*;
(
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	// host bus (asynchronous pins)
	input wire sbd_bus_type bus_i,
	output logic [7:0] rdata_o,
	output logic rdata_oe_o,
	// jumpers: bit set means fitted
	input wire logic [JMP_W-1:0] base_select_jumpers_i,
	input wire logic [IRQ_N-1:0] irq_jumpers_i,
	output logic [IRQ_N-1:0] irq_o,
	output logic [IRQ_N-1:0] irq_oe_o,
	// measurement engine side
	input wire logic [MEAS_W-1:0] meas_i,
	input wire logic meas_valid_i,
	output logic [CH_W-1:0] scan_ch_o,
	input wire sbd_limit_type [CH_N-1:0] limits_i,
	// command processor side
	output logic [7:0] cmd_byte_o,
	output logic cmd_valid_o,
	input wire logic [7:0] resp_byte_i,
	input wire logic resp_valid_i,
	input wire logic comm_event_i,
	output logic [MEAS_W-1:0] meas_rd_o,
	input wire logic [CH_W-1:0] meas_rd_ch_i
);

	// two-stage synchronisers for all bus pins
	sbd_bus_type bus_s1, bus_s2, next_bus_s1, next_bus_s2;
	logic [JMP_W-1:0] jb_s1, jb_s2;
	logic [IRQ_N-1:0] ji_s1, ji_s2;
	always_comb begin
		next_bus_s1 = bus_i;
		next_bus_s2 = bus_s1;
	end
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			bus_s1 <= '{addr: '0, aen: 1'b1, ior_n: 1'b1, iow_n: 1'b1, wdata: '0};
			bus_s2 <= '{addr: '0, aen: 1'b1, ior_n: 1'b1, iow_n: 1'b1, wdata: '0};
			jb_s1 <= JMP_FACTORY;
			jb_s2 <= JMP_FACTORY;
			ji_s1 <= '0;
			ji_s2 <= '0;
		end else begin
			bus_s1 <= next_bus_s1;
			bus_s2 <= next_bus_s2;
			jb_s1 <= base_select_jumpers_i;
			jb_s2 <= jb_s1;
			ji_s1 <= irq_jumpers_i;
			ji_s2 <= ji_s1;
		end
	end

	// address match: upper six bits ignored so images repeat each 0x400
	logic hit, sel_data, sel_ctrl;
	always_comb begin
		hit = !bus_s2.aen; // see [R12]
		for (int i = 0; i < JMP_W; i++) begin
			hit = hit && (bus_s2.addr[DEC_LO+i] == !jb_s2[i]); // see [R2] see [R3] see [R4]
		end
		sel_data = hit && (bus_s2.addr[OFS_W-1:0] == OFS_DATA); // see [R1]
		sel_ctrl = hit && (bus_s2.addr[OFS_W-1:0] == OFS_CTRL); // see [R1]
	end

	// strobe edge detection on synchronised copies only
	logic ior_d, iow_d, next_ior_d, next_iow_d;
	logic rd_start, wr_start;
	always_comb begin
		next_ior_d = bus_s2.ior_n;
		next_iow_d = bus_s2.iow_n;
		rd_start = ior_d && !bus_s2.ior_n;
		wr_start = iow_d && !bus_s2.iow_n;
	end

	// scan sequencer and result store
	logic [15:0] step_cnt, next_step_cnt;
	logic [CH_W-1:0] scan_ch, next_scan_ch;
	logic [MEAS_W-1:0] meas_mem [CH_N];
	logic [CH_N-1:0] viol, next_viol;
	always_comb begin
		next_step_cnt = step_cnt + 16'h0001;
		next_scan_ch = scan_ch;
		if (step_cnt == SCAN_LAST) begin
			next_step_cnt = 16'h0000;
			next_scan_ch = scan_ch + 3'h1; // see [R8]
		end
		next_viol = viol;
		if (meas_valid_i) begin
			next_viol[scan_ch] = ($signed(meas_i) < limits_i[scan_ch].lo) ||
				($signed(meas_i) > limits_i[scan_ch].hi); // see [R9]
		end
	end
	always_ff @(posedge ref_clk_i) begin
		if (meas_valid_i) begin
			meas_mem[scan_ch] <= meas_i; // see [R8]
		end
	end

	// data port, status and control
	logic [7:0] cmd_byte, next_cmd_byte, resp, next_resp;
	logic cmd_valid, next_cmd_valid, rx_rdy, next_rx_rdy;
	logic alarm, next_alarm, ien_alarm, next_ien_alarm, ien_comm, next_ien_comm;
	logic comm_pend, next_comm_pend;
	logic [7:0] rdata, next_rdata, status;
	logic rdata_oe, next_rdata_oe;
	logic [IRQ_N-1:0] irq_oe, next_irq_oe;
	always_comb begin
		status = 8'h00;
		status[ST_ALARM] = alarm;
		status[ST_RXRDY] = rx_rdy;
		status[ST_TXBUSY] = cmd_valid;
		next_cmd_byte = cmd_byte;
		next_cmd_valid = 1'b0;
		next_resp = resp;
		next_rx_rdy = rx_rdy;
		next_ien_alarm = ien_alarm;
		next_ien_comm = ien_comm;
		next_alarm = alarm;
		next_comm_pend = comm_pend;
		next_rdata = rdata;
		next_rdata_oe = !bus_s2.ior_n && (sel_data || sel_ctrl);
		if (wr_start && sel_data) begin // see [R10]
			next_cmd_byte = bus_s2.wdata;
			next_cmd_valid = 1'b1;
		end
		if (wr_start && sel_ctrl) begin // see [R11]
			next_ien_alarm = bus_s2.wdata[CT_IEN_ALARM];
			next_ien_comm = bus_s2.wdata[CT_IEN_COMM];
			if (bus_s2.wdata[CT_ACK_ALARM]) begin
				next_alarm = 1'b0;
			end
		end
		if (rd_start && sel_data) begin // see [R10]
			next_rdata = resp;
			next_rx_rdy = 1'b0;
			next_comm_pend = 1'b0;
		end
		if (rd_start && sel_ctrl) begin
			next_rdata = status; // see [R11]
		end
		// new events win over a same-cycle clear
		if (resp_valid_i) begin
			next_resp = resp_byte_i;
			next_rx_rdy = 1'b1;
		end
		if (comm_event_i || resp_valid_i) begin
			next_comm_pend = 1'b1;
		end
		if (|viol) begin
			next_alarm = 1'b1; // see [R9]
		end
		// one shared request onto the single fitted line; none fitted drives none
		for (int i = 0; i < IRQ_N; i++) begin
			next_irq_oe[i] = ji_s2[i] && ($countones(ji_s2) == 1); // see [R7]
		end
	end
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			ior_d <= 1'b1;
			iow_d <= 1'b1;
			step_cnt <= 16'h0000;
			scan_ch <= 3'h0;
			viol <= '0;
			cmd_byte <= 8'h00;
			cmd_valid <= 1'b0;
			resp <= 8'h00;
			rx_rdy <= 1'b0;
			alarm <= 1'b0;
			ien_alarm <= 1'b0; // see [R5]
			ien_comm <= 1'b0;
			comm_pend <= 1'b0;
			rdata <= 8'h00;
			rdata_oe <= 1'b0;
			irq_oe <= '0;
		end else begin
			ior_d <= next_ior_d;
			iow_d <= next_iow_d;
			step_cnt <= next_step_cnt;
			scan_ch <= next_scan_ch;
			viol <= next_viol;
			cmd_byte <= next_cmd_byte;
			cmd_valid <= next_cmd_valid;
			resp <= next_resp;
			rx_rdy <= next_rx_rdy;
			alarm <= next_alarm;
			ien_alarm <= next_ien_alarm;
			ien_comm <= next_ien_comm;
			comm_pend <= next_comm_pend;
			rdata <= next_rdata;
			rdata_oe <= next_rdata_oe;
			irq_oe <= next_irq_oe;
		end
	end

	// request level merged from all sources
	logic irq_lvl, next_irq_lvl;
	always_comb begin
		next_irq_lvl = (alarm && ien_alarm) || (comm_pend && ien_comm); // see [R6]
	end
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			irq_lvl <= 1'b0;
		end else begin
			irq_lvl <= next_irq_lvl;
		end
	end
	logic [MEAS_W-1:0] meas_rd;
	always_ff @(posedge ref_clk_i) begin
		meas_rd <= meas_mem[meas_rd_ch_i]; // see [R8]
	end

	assign rdata_o = rdata;
	assign rdata_oe_o = rdata_oe;
	assign irq_o = {IRQ_N{irq_lvl}};
	assign irq_oe_o = irq_oe;
	assign scan_ch_o = scan_ch;
	assign cmd_byte_o = cmd_byte;
	assign cmd_valid_o = cmd_valid;
	assign meas_rd_o = meas_rd;

endmodule : sbd_io_decode

// ### dv/sbd_io_decode_sva.sv
`timescale 1ns/100ps
module sbd_io_decode_sva
	import sbd_pkg::*;
(
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	// watched ports
	input wire sbd_bus_type bus_i,
	input wire logic rdata_oe_o,
	input wire logic [JMP_W-1:0] base_select_jumpers_i,
	input wire logic [IRQ_N-1:0] irq_o,
	input wire logic [IRQ_N-1:0] irq_oe_o,
	input wire logic [CH_W-1:0] scan_ch_o,
	input wire logic cmd_valid_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n_i);
	property p_oe_one; $onehot0(irq_oe_o); endproperty
	property p_irq_same; irq_o == '0 || irq_o == '1; endproperty
	property p_scan; $changed(scan_ch_o) |-> scan_ch_o == $past(scan_ch_o) + 3'h1; endproperty
	// a read answer needs its strobe three edges back: two sync stages plus the rdata_oe register
	property p_rd_cause; $rose(rdata_oe_o) |-> !$past(bus_i.ior_n, 3) && !$past(bus_i.aen, 3);
	endproperty
	property p_rd_ofs; $rose(rdata_oe_o) |-> $past(bus_i.addr[1:0], 3) <= 2'h1; endproperty
	property p_rd_dec; $rose(rdata_oe_o) |-> $past(bus_i.addr[9:2], 3) == ~base_select_jumpers_i;
	endproperty
	property p_cmd_cause;
		cmd_valid_o |-> !$past(bus_i.iow_n, 3) && $past(bus_i.addr[1:0], 3) == 2'h0;
	endproperty
	property p_cmd_pulse; cmd_valid_o |=> !cmd_valid_o; endproperty
	a_oe_one: assert property (p_oe_one) else $error("irq enable not one-hot");
	a_irq_same: assert property (p_irq_same) else $error("irq lines differ");
	a_scan: assert property (p_scan) else $error("scan step wrong");
	a_rd_cause: assert property (p_rd_cause) else $error("read drive uncaused");
	a_rd_ofs: assert property (p_rd_ofs) else $error("read at unused offset");
	a_rd_dec: assert property (p_rd_dec) else $error("read base mismatch");
	a_cmd_cause: assert property (p_cmd_cause) else $error("command uncaused");
	a_cmd_pulse: assert property (p_cmd_pulse) else $error("command pulse long");
	c_rd: cover property ($rose(rdata_oe_o));
	c_cmd: cover property (cmd_valid_o);
	c_irq: cover property (irq_oe_o != '0 && irq_o == '1);
endmodule : sbd_io_decode_sva
bind sbd_io_decode sbd_io_decode_sva u_sva (.ref_clk_i, .rst_n_i, .bus_i, .rdata_oe_o,
	.base_select_jumpers_i, .irq_o, .irq_oe_o, .scan_ch_o, .cmd_valid_o);

// ### dv/sbd_host.sv
`timescale 1ns/100ps
module sbd_host
	import sbd_pkg::*;
(
	input wire logic ref_clk_i,
	output sbd_bus_type bus_o
);
	initial bus_o = {16'h0000, 1'b0, 1'b1, 1'b1, 8'h00};
	// 6-cycle phases, three times the two-stage synchroniser depth
	task automatic cyc(input logic [15:0] a, input logic wr, input logic [7:0] d, input logic dma);
		@(posedge ref_clk_i) #1;
		bus_o.addr = a;
		bus_o.aen = dma;
		bus_o.wdata = d;
		@(posedge ref_clk_i) #1;
		if (wr) bus_o.iow_n = 1'b0;
		else bus_o.ior_n = 1'b0;
		repeat (6) @(posedge ref_clk_i);
		#1 bus_o.ior_n = 1'b1;
		bus_o.iow_n = 1'b1;
		repeat (6) @(posedge ref_clk_i);
		// released data lines must not keep the last byte
		#1 bus_o.wdata = ~d;
	endtask : cyc
endmodule : sbd_host

// ### dv/sbd_io_decode_tb.sv
`timescale 1ns/100ps
module sbd_io_decode_tb
	import sbd_pkg::*;
;
	logic ref_clk_i = 1'b0, rst_n_i = 1'b0, rdata_oe_o, meas_valid_i, resp_valid_i, cmd_valid_o;
	logic comm_event_i = 1'b0, oe_q = 1'b0;
	sbd_bus_type bus_i;
	logic [7:0] rdata_o, cmd_byte_o, resp_byte_i, jmp, d;
	logic [IRQ_N-1:0] irq_j, irq_o, irq_oe_o;
	logic [MEAS_W-1:0] meas_i, meas_rd_o;
	logic [CH_W-1:0] scan_ch_o, rd_ch;
	sbd_limit_type [CH_N-1:0] lim;
	logic [7:0] exp_q[$];
	// refused locations: offsets two and three, then a base off by one bit
	logic [15:0] bad_a [4] = '{16'h02B2, 16'h02B3, 16'h02F1, 16'h06F0};
	int err_total, total_checks, cyc_n, seed;
	sbd_io_decode u_sbd_io_decode (.ref_clk_i, .rst_n_i, .bus_i, .rdata_o, .rdata_oe_o,
		.base_select_jumpers_i(jmp), .irq_jumpers_i(irq_j), .irq_o, .irq_oe_o, .meas_i,
		.meas_valid_i, .scan_ch_o, .limits_i(lim), .cmd_byte_o, .cmd_valid_o, .resp_byte_i,
		.resp_valid_i, .comm_event_i, .meas_rd_o, .meas_rd_ch_i(rd_ch));
	sbd_host u_sbd_host (.ref_clk_i, .bus_o(bus_i));
	initial forever #2 ref_clk_i = ~ref_clk_i;
	task automatic check(input logic [15:0] s, input logic [15:0] e);
		total_checks++;
		if (s !== e) begin
			err_total++;
			$display("ERROR t=%0t seen %h expected %h", $time, s, e);
		end
	endtask : check
	task results;
		if (err_total == 0 && total_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : results
	task automatic acc(input logic [15:0] a, input logic wr, input logic [7:0] v, input logic dma);
		if (dma == 1'b0 && a[1:0] <= 2'h1 && !(wr && a[0]) && a[9:2] == ~jmp) exp_q.push_back(v);
		u_sbd_host.cyc(a, wr, v, dma);
	endtask : acc
	// results are matched oldest first against the notes in exp_q
	always @(posedge ref_clk_i) begin
		if ((rdata_oe_o && !oe_q) || cmd_valid_o) begin
			if (exp_q.size() == 0) check(16'hFFFF, 16'h0000);
			else check(cmd_valid_o ? cmd_byte_o : rdata_o, exp_q.pop_front());
		end
		oe_q = rdata_oe_o;
		meas_valid_i <= #1 (cyc_n % 50 == 0);
		meas_i <= #1 16'h0100 + 16'(scan_ch_o);
		if (++cyc_n == 40000) begin
			err_total++;
			results();
		end
	end
	initial begin
		seed = 32'h3a5b5599;
		{jmp, irq_j, rd_ch, resp_byte_i, resp_valid_i} = {JMP_FACTORY, 6'h00, 3'h0, 9'h000};
		for (int i = 0; i < CH_N; i++) lim[i] = {16'h8000, 16'h7FFF};
		repeat (2) @(posedge ref_clk_i);
		#1 rst_n_i = 1'b1;
		repeat (3) @(posedge ref_clk_i);
		acc(16'h02B1, 1'b0, 8'h00, 1'b0);
		d = 8'($random(seed));
		acc({6'($random(seed)), 10'h2B0}, 1'b1, d, 1'b0);
		for (int i = 0; i < 4; i++) begin
			acc(bad_a[i], i[0], d, 1'b0);
		end
		acc(16'h02B1, 1'b0, 8'h00, 1'b1);
		@(posedge ref_clk_i) #1 {resp_byte_i, resp_valid_i} = {d ^ 8'hA5, 1'b1};
		@(posedge ref_clk_i) #1 resp_valid_i = 1'b0;
		// response waiting shows in status before the data read clears it
		acc(16'h02B1, 1'b0, 8'h02, 1'b0);
		acc(16'h02B0, 1'b0, d ^ 8'hA5, 1'b0);
		jmp = 8'h1B;
		acc(16'h0390, 1'b1, d, 1'b0);
		acc(16'h02B0, 1'b1, d, 1'b0);
		{jmp, irq_j} = {JMP_FACTORY, 6'h04};
		for (int i = 0; i < CH_N; i++) lim[i].hi = 16'h0000;
		repeat (2100) @(posedge ref_clk_i);
		acc(16'h02B1, 1'b1, 8'h01, 1'b0);
		repeat (10) @(posedge ref_clk_i);
		check({irq_oe_o, irq_o}, 12'h13F);
		// alarm source masked, communication source enabled but idle
		acc(16'h02B1, 1'b1, 8'h02, 1'b0);
		repeat (10) @(posedge ref_clk_i);
		check({irq_oe_o, irq_o}, 12'h100);
		#1 comm_event_i = 1'b1;
		@(posedge ref_clk_i) #1 comm_event_i = 1'b0;
		repeat (10) @(posedge ref_clk_i);
		check({irq_oe_o, irq_o}, 12'h13F);
		for (int i = 0; i < 2; i++) begin
			#1 irq_j = i[0] ? 6'h00 : 6'h0C;
			repeat (10) @(posedge ref_clk_i);
			check(irq_oe_o, 6'h00);
		end
		for (int k = 0; k < CH_N; k++) begin
			#1 rd_ch = 3'(k);
			repeat (2) @(posedge ref_clk_i);
			check(meas_rd_o, 16'h0100 + 16'(k));
		end
		check(16'(exp_q.size()), 16'h0000);
		results();
	end
endmodule : sbd_io_decode_tb
